// ---- hw/aspm_uart.sv ----
// asynchronous serial port: 10-bit and 11-bit frame modes, with tx fifo
// assumes timer overflow pulses come from logic on ref_clk; rx_pin is async
//
// Contract
// - 10-bit frame: low start, 8 data bits LSB first, high stop.
// - 10-bit mode: accepted frame stores stop bit as received ninth bit.
// - buffer write loads shifter, ninth=1 in 10-bit; start at next rollover.
// - start bit first, data output one bit later, first shift after another.
// - 10-bit: zeros shift in; final shift, done flag at 10th rollover.
// - falling edge at 16x sampling starts receive; counter reset, load 1FF.
// - sample at counter states 7, 8, 9; take two-of-three majority.
// - nonzero first bit resets receiver back to edge search.
// - 10-bit: start at end position gives final shift and gated load.
// - 10-bit: after final shift always return to edge search.
// - failed acceptance loses frame; flag, buffer, ninth bit unchanged.
// - 11-bit frame: start, 8 data LSB first, programmed ninth, stop.
// - fixed 11-bit mode: oscillator over 64, or 32 with baud double.
// - variable modes use timer 1 or 2 per direction by select bits.
// - 11-bit: load ninth bit; first shift inserts stop, then zeros.
// - 11-bit: final shift and done flag at 11th rollover.
// - 11-bit: accept if flag clear and filter off or ninth bit one.
// - 11-bit: resume edge search one bit time after final shift.
// - 11-bit: received stop bit affects nothing.
// - timer 1 rate: overflow rate times two to baud double over 32.
// - timer 2 rate: overflow rate over 16.
`timescale 1ns/1ns
`include "aspm_defines.svh"

// ****************************************
// transmit fifo
// ****************************************
module aspm_fifo
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = `ASPM_FIFO_DEPTH
)
(
	input  wire logic             ref_clk,
	input  wire logic             rst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	wire              push = in_valid && in_ready;
	wire              pop  = out_valid && out_ready;

	assign in_ready  = count != (AW+1)'(DEPTH);
	assign out_valid = count != '0;
	assign out_data  = mem[rd_ptr];

	always_ff @(posedge ref_clk)
	begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : aspm_fifo

// ****************************************
// serial port
// ****************************************
module aspm_uart
(
	input  wire logic                      ref_clk,
	input  wire logic                      rst,
	input  wire aspm_pkg::aspm_cfg_type    cfg,
	input  wire logic                      timer1_ovf,
	input  wire logic                      timer2_ovf,
	input  wire logic                      wr_valid,
	output logic                           wr_ready,
	input  wire logic [7:0]                wr_data,
	output logic                           tx_done_flag,
	input  wire logic                      tx_done_clear,
	output logic                           rx_done_flag,
	input  wire logic                      rx_done_clear,
	output aspm_pkg::aspm_rx_word_type     rx_word,
	input  wire logic                      rx_pin,
	output logic                           tx_pin
);
	import aspm_pkg::*;

	typedef enum logic [1:0]
	{
		TX_IDLE  = 2'b00,
		TX_WAIT  = 2'b01,
		TX_START = 2'b11,
		TX_DATA  = 2'b10
	} aspm_tx_state_type;

	typedef enum logic [1:0]
	{
		RX_IDLE  = 2'b00,
		RX_FRAME = 2'b01,
		RX_TAIL  = 2'b11
	} aspm_rx_state_type;

	function automatic logic aspm_maj3(input logic a, input logic b, input logic c);
		aspm_maj3 = (a & b) | (a & c) | (b & c);
	endfunction : aspm_maj3

	// ****************************************
	// 16x tick generation
	// ****************************************
	logic [1:0] osc_cnt;
	logic       t1_half;
	wire        osc_tick = cfg.baud_double ? osc_cnt[0] : (osc_cnt == `ASPM_OSC_LAST);
	wire        t1_tick  = timer1_ovf && (cfg.baud_double || t1_half);
	wire        t2_tick  = timer2_ovf;
	wire        active   = cfg.mode != ASPM_MODE_SHIFT;
	wire        eleven   = cfg.mode[1];
	wire        tx_tick  = active && ((cfg.mode == ASPM_MODE_FIXED) ? osc_tick
	                     : (cfg.tx_timer_select ? t2_tick : t1_tick));
	wire        rx_tick  = active && ((cfg.mode == ASPM_MODE_FIXED) ? osc_tick
	                     : (cfg.rx_timer_select ? t2_tick : t1_tick));

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			osc_cnt <= 2'h0;
			t1_half <= 1'b0;
		end
		else
		begin
			osc_cnt <= osc_cnt + 2'h1;
			if (timer1_ovf)
				t1_half <= ~t1_half;
		end
	end

	// ****************************************
	// transmitter
	// ****************************************
	aspm_tx_state_type tx_state;
	logic [3:0]        tx_cnt;
	logic [8:0]        tsr;
	logic              tx_shifted;
	logic [7:0]        fifo_data;
	logic              fifo_valid;
	wire               tx_roll  = tx_tick && (tx_cnt == `ASPM_CNT_LAST);
	wire               tx_load  = fifo_valid && (tx_state == TX_IDLE) && active;
	// marker one sits just left of the last bit at the output
	wire               tx_last  = tx_shifted && (tsr[8:1] == `ASPM_TX_END_MARK);
	wire               tx_first = !tx_shifted && eleven;

	aspm_fifo
	#(
		.WIDTH (8),
		.DEPTH (`ASPM_FIFO_DEPTH)
	)
	u_fifo
	(
		.ref_clk   (ref_clk),
		.rst       (rst),
		.in_valid  (wr_valid),
		.in_ready  (wr_ready),
		.in_data   (wr_data),
		.out_valid (fifo_valid),
		.out_ready (tx_load),
		.out_data  (fifo_data)
	);

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			tx_state     <= TX_IDLE;
			tx_cnt       <= 4'h0;
			tsr          <= 9'h000;
			tx_shifted   <= 1'b0;
			tx_pin       <= 1'b1;
			tx_done_flag <= 1'b0;
		end
		else
		begin
			if (tx_tick)
				tx_cnt <= tx_cnt + 4'h1;
			if (tx_done_clear)
				tx_done_flag <= 1'b0;
			unique case (tx_state)
				TX_IDLE:
				begin
					tx_pin <= 1'b1;
					if (tx_load)
					begin
						tsr        <= {eleven ? cfg.tx_ninth_bit : 1'b1, fifo_data};
						tx_shifted <= 1'b0;
						tx_state   <= TX_WAIT;
					end
				end
				TX_WAIT:
					if (tx_roll)
					begin
						tx_pin   <= 1'b0;
						tx_state <= TX_START;
					end
				TX_START:
					if (tx_roll)
					begin
						tx_pin   <= tsr[0];
						tx_state <= TX_DATA;
					end
				TX_DATA:
					if (tx_roll)
					begin
						// first 11-bit shift inserts the stop bit, zeros after
						tsr        <= {tx_first, tsr[8:1]};
						tx_shifted <= 1'b1;
						tx_pin     <= tx_last ? 1'b1 : tsr[1];
						if (tx_last)
						begin
							tx_done_flag <= 1'b1;
							tx_state     <= TX_IDLE;
						end
					end
				default:
					tx_state <= TX_IDLE;
			endcase
		end
	end

	// ****************************************
	// receiver
	// ****************************************
	logic              rx_s1;
	logic              rx_s2;
	logic              rx_last;
	logic              samp_a;
	logic              samp_b;
	aspm_rx_state_type rx_state;
	logic [3:0]        rx_cnt;
	logic [8:0]        rsr;
	logic              rx_first;
	wire               rx_vote   = aspm_maj3(samp_a, samp_b, rx_s2);
	wire               rx_decide = rx_tick && (rx_cnt == `ASPM_SAMPLE_C);
	wire               rx_edge   = rx_tick && rx_last && !rx_s2;
	// start bit reached the end position: this bit is the final one
	wire               rx_final  = !rx_first && !rsr[0];
	wire               rx_accept = !rx_done_flag && (!cfg.multiproc_filter || rx_vote);

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			rx_s1 <= 1'b1;
			rx_s2 <= 1'b1;
		end
		else
		begin
			rx_s1 <= rx_pin;
			rx_s2 <= rx_s1;
		end
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			rx_last      <= 1'b1;
			samp_a       <= 1'b1;
			samp_b       <= 1'b1;
			rx_state     <= RX_IDLE;
			rx_cnt       <= 4'h0;
			rsr          <= `ASPM_RX_PRESET;
			rx_first     <= 1'b1;
			rx_done_flag <= 1'b0;
			rx_word      <= '0;
		end
		else
		begin
			if (rx_tick)
			begin
				rx_last <= rx_s2;
				rx_cnt  <= rx_cnt + 4'h1;
			end
			if (rx_tick && rx_cnt == `ASPM_SAMPLE_A)
				samp_a <= rx_s2;
			if (rx_tick && rx_cnt == `ASPM_SAMPLE_B)
				samp_b <= rx_s2;
			if (rx_done_clear)
				rx_done_flag <= 1'b0;
			unique case (rx_state)
				RX_IDLE:
					if (rx_edge)
					begin
						rx_cnt   <= 4'h1; // edge tick counts as state zero
						rsr      <= `ASPM_RX_PRESET;
						rx_first <= 1'b1;
						rx_state <= RX_FRAME;
					end
				RX_FRAME:
					if (rx_decide)
					begin
						rx_first <= 1'b0;
						// shifter is mirrored: bits enter on the left, oldest at bit 0
						rsr <= {rx_vote, rsr[8:1]};
						if (rx_first && rx_vote)
							rx_state <= RX_IDLE;
						else if (rx_final)
						begin
							if (rx_accept)
							begin
								// 10-bit: vote is the stop bit; 11-bit: the ninth bit
								rx_word      <= {rx_vote, rsr[8:1]};
								rx_done_flag <= 1'b1;
							end
							rx_state <= eleven ? RX_TAIL : RX_IDLE;
						end
					end
				RX_TAIL:
					if (rx_decide)
						rx_state <= RX_IDLE; // stop bit is ignored
				default:
					rx_state <= RX_IDLE;
			endcase
			if (!active)
				rx_state <= RX_IDLE;
		end
	end
endmodule : aspm_uart

// ---- common/aspm_defines.svh ----
// constants for the asynchronous serial port: counts, presets, sample points
// assumes inclusion by the serial port design file only
`ifndef ASPM_DEFINES_SVH
`define ASPM_DEFINES_SVH

// ****************************************
// bit timing
// ****************************************
`define ASPM_CNT_LAST     4'hF
`define ASPM_SAMPLE_A     4'h7
`define ASPM_SAMPLE_B     4'h8
`define ASPM_SAMPLE_C     4'h9
`define ASPM_OSC_LAST     2'h3

// ****************************************
// shift register values and fifo depth
// ****************************************
`define ASPM_RX_PRESET    9'h1FF
`define ASPM_TX_END_MARK  8'h01
`define ASPM_FIFO_DEPTH   16

`endif

// ---- common/aspm_pkg.sv ----
// types shared by the serial port and its users
// assumes nothing beyond a SystemVerilog compiler
package aspm_pkg;

	// ****************************************
	// modes and carriers
	// ****************************************
	typedef enum logic [1:0]
	{
		ASPM_MODE_SHIFT = 2'h0,
		ASPM_MODE_TEN   = 2'h1,
		ASPM_MODE_FIXED = 2'h2,
		ASPM_MODE_VAR   = 2'h3
	} aspm_mode_type;

	typedef struct packed
	{
		aspm_mode_type mode;
		logic          baud_double;
		logic          multiproc_filter;
		logic          tx_ninth_bit;
		logic          tx_timer_select;
		logic          rx_timer_select;
	} aspm_cfg_type;

	typedef struct packed
	{
		logic       rx_ninth_bit;
		logic [7:0] serial_buffer;
	} aspm_rx_word_type;

endpackage : aspm_pkg

// ---- testbench/aspm_uart_asserts.sv ----
// checker for the serial port: tx_pin timing, flags and rx_word
// assumes a bind to aspm_uart; one clock, reset active high
`timescale 1ns/1ns
module aspm_uart_asserts
(
	input wire logic                       ref_clk,
	input wire logic                       rst,
	input wire aspm_pkg::aspm_cfg_type     cfg,
	input wire logic                       wr_valid,
	input wire logic                       wr_ready,
	input wire logic                       tx_done_flag,
	input wire logic                       tx_done_clear,
	input wire logic                       rx_done_flag,
	input wire logic                       rx_done_clear,
	input wire aspm_pkg::aspm_rx_word_type rx_word,
	input wire logic                       tx_pin
);
	import aspm_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	logic [9:0] run_lo;
	logic [9:0] run_hi;
	wire        fixed   = cfg.mode == ASPM_MODE_FIXED;
	wire        flt     = cfg.multiproc_filter;
	wire  [9:0] bit_len = cfg.baud_double ? 10'h020 : 10'h040;
	// high runs saturate so a first frame after reset is not flagged
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			run_lo <= 10'h000;
			run_hi <= 10'h3FF;
		end
		else
		begin
			run_lo <= tx_pin ? 10'h000 : run_lo + 10'h001;
			run_hi <= !tx_pin ? 10'h000 : run_hi + {9'h000, run_hi != 10'h3FF};
		end
	end
	// ****
	// properties
	// ****
	sequence s_done_rise;
		!tx_done_flag ##1 tx_done_flag;
	endsequence
	sequence s_stop_held;
		tx_pin [*8];
	endsequence
	AST_STOP_AFTER_DONE: assert property (s_done_rise |-> s_stop_held)
		else $error("no stop after done");
	AST_LOW_RUN: assert property ($rose(tx_pin) && fixed |-> run_lo % bit_len == 10'h000)
		else $error("low run not whole bits");
	AST_HIGH_RUN: assert property ($fell(tx_pin) && fixed |-> run_hi >= bit_len)
		else $error("high run too short");
	AST_TXDONE_HOLD: assert property ($fell(tx_done_flag) |-> $past(tx_done_clear))
		else $error("tx done lost");
	AST_RXDONE_HOLD: assert property ($fell(rx_done_flag) |-> $past(rx_done_clear))
		else $error("rx done lost");
	AST_WORD_ON_FLAG: assert property ($changed(rx_word) |-> $rose(rx_done_flag))
		else $error("rx word changed alone");
	AST_FILTER_NINTH: assert property ($rose(rx_done_flag) && flt |-> rx_word.rx_ninth_bit)
		else $error("filter passed zero");
	AST_READY_DROP: assert property ($fell(wr_ready) |-> $past(wr_valid))
		else $error("ready dropped alone");
endmodule : aspm_uart_asserts

bind aspm_uart aspm_uart_asserts aspm_uart_asserts_inst (.ref_clk(ref_clk), .rst(rst),
	.cfg(cfg), .wr_valid(wr_valid), .wr_ready(wr_ready), .tx_done_flag(tx_done_flag),
	.tx_done_clear(tx_done_clear), .rx_done_flag(rx_done_flag),
	.rx_done_clear(rx_done_clear), .rx_word(rx_word), .tx_pin(tx_pin));

// ---- testbench/aspm_remote.sv ----
// remote serial node: sends frames on rx_pin, catches frames on tx_pin
// assumes bit lengths in ref_clk cycles come from the bench
`timescale 1ns/1ns
module aspm_remote
(
	input wire logic       ref_clk,
	input wire logic [7:0] bit_in,
	input wire logic [7:0] bit_out,
	input wire logic       eleven,
	input wire logic       tx_pin,
	output logic           rx_pin
);
	logic [9:0] got[$];
	logic [9:0] f;
	initial rx_pin = 1'b1;
	task automatic hold(input int k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask : hold
	// lo above zero puts a short false start before the frame
	task automatic send(input logic [10:0] v, input int n, input int lo);
		rx_pin = 1'b0;
		hold(lo);
		rx_pin = 1'b1;
		hold(2 * bit_in);
		for (int i = 0; i < n; i++)
		begin
			rx_pin = v[i];
			hold(bit_in / 2);
			// one-cycle spike on data bits only, never where edge search runs
			rx_pin = v[i] ^ (i > 0 && i < 9);
			hold(1);
			rx_pin = v[i];
			hold(bit_in - bit_in / 2 - 1);
		end
		rx_pin = 1'b1;
	endtask : send
	always
	begin
		@(negedge tx_pin);
		hold(bit_out / 2);
		for (int k = 0; k < (eleven ? 10 : 9); k++)
		begin
			hold(bit_out);
			f[k] = tx_pin;
		end
		got.push_back(eleven ? f : {f[8], 1'b1, f[7:0]});
	end
endmodule : aspm_remote

// ---- testbench/testbench.sv ----
// self-checking bench: serial port against the remote serial node
// assumes design, checker and remote node are compiled before it
`timescale 1ns/1ns
module testbench;
	import aspm_pkg::*;
	logic             ref_clk = 1'b0;
	logic             rst = 1'b1;
	aspm_cfg_type     cfg = '0;
	logic             timer1_ovf = 1'b0;
	logic             timer2_ovf = 1'b0;
	logic             wr_valid = 1'b0;
	logic [7:0]       wr_data = 8'h00;
	logic             tx_done_clear = 1'b0;
	logic             rx_done_clear = 1'b0;
	logic             wr_ready, tx_done_flag, rx_done_flag, rx_pin, tx_pin;
	aspm_rx_word_type rx_word;
	logic [8:0]       exp_word = 9'h000;
	logic             exp_flag = 1'b0;
	logic [31:0]      seed = 32'h0000001B;
	logic [7:0]       sent[$];
	logic [7:0]       r;
	logic [6:0]       table_cfg [6] = '{7'h20, 7'h32, 7'h40, 7'h50, 7'h71, 7'h63};
	int               n_errors = 0;
	int               checks_done = 0;
	int               ovf_cnt = 0;
	wire              ten = cfg.mode == ASPM_MODE_TEN;
	// timer 1 overflows every 2 cycles, timer 2 every 3
	function automatic logic [7:0] blen(input aspm_cfg_type c, input logic t2);
		if (c.mode == ASPM_MODE_FIXED || !t2)
			return c.baud_double ? 8'h20 : 8'h40;
		return 8'h30;
	endfunction : blen
	function automatic logic [7:0] xorshift();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction : xorshift
	initial forever #20 ref_clk = ~ref_clk;
	always @(posedge ref_clk)
	begin
		#1;
		ovf_cnt++;
		timer1_ovf = ovf_cnt % 2 == 0;
		timer2_ovf = ovf_cnt % 3 == 0;
	end
	aspm_uart aspm_uart_inst (.ref_clk(ref_clk), .rst(rst), .cfg(cfg), .timer1_ovf(timer1_ovf),
		.timer2_ovf(timer2_ovf), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
		.tx_done_flag(tx_done_flag), .tx_done_clear(tx_done_clear), .rx_done_flag(rx_done_flag),
		.rx_done_clear(rx_done_clear), .rx_word(rx_word), .rx_pin(rx_pin), .tx_pin(tx_pin));
	aspm_remote aspm_remote_inst (.ref_clk(ref_clk), .bit_in(blen(cfg, cfg.rx_timer_select)),
		.bit_out(blen(cfg, cfg.tx_timer_select)), .eleven(!ten), .tx_pin(tx_pin), .rx_pin(rx_pin));
	// ****
	// tasks
	// ****
	task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : check
	task automatic stop_test();
		$display("checks %0d, errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : stop_test
	task automatic push(input logic [7:0] d);
		sent.push_back(d);
		wr_data = d;
		wr_valid = 1'b1;
		do @(posedge ref_clk); while (wr_ready !== 1'b1);
		#1;
	endtask : push
	task automatic drain();
		logic [9:0] want;
		for (int k = 0; k < 60000 && aspm_remote_inst.got.size() < sent.size(); k++)
			@(posedge ref_clk);
		aspm_remote_inst.hold(1);
		check("tx done", {9'h000, tx_done_flag}, 10'h001);
		while (sent.size() > 0 && aspm_remote_inst.got.size() > 0)
		begin
			want = {1'b1, ten | cfg.tx_ninth_bit, sent.pop_front()};
			check("tx frame", aspm_remote_inst.got.pop_front(), want);
		end
		check("tx left", 10'(sent.size()), 10'h000);
		tx_done_clear = 1'b1;
		aspm_remote_inst.hold(1);
		tx_done_clear = 1'b0;
	endtask : drain
	task automatic rx(input logic [7:0] d, input logic nb, input logic st, input logic flt,
		input int lo);
		logic eff;
		eff = ten ? st : nb;
		cfg.multiproc_filter = flt;
		aspm_remote_inst.send(ten ? {1'b1, st, d, 1'b0} : {st, nb, d, 1'b0}, ten ? 10 : 11, lo);
		if (!exp_flag && (!flt || eff))
		begin
			exp_word = {eff, d};
			exp_flag = 1'b1;
		end
		aspm_remote_inst.hold(2);
		check("rx flag", {9'h000, rx_done_flag}, {9'h000, exp_flag});
		check("rx word", {1'b0, rx_word}, {1'b0, exp_word});
	endtask : rx
	task automatic rx_clear();
		rx_done_clear = 1'b1;
		aspm_remote_inst.hold(1);
		rx_done_clear = 1'b0;
		exp_flag = 1'b0;
	endtask : rx_clear
	initial
	begin
		repeat (90000) @(posedge ref_clk);
		n_errors++;
		stop_test();
	end
	initial
	begin
		aspm_remote_inst.hold(16);
		rst = 1'b0;
		check("idle", {tx_pin, rx_word}, 10'h200);
		check("idle flags", {7'h00, wr_ready, tx_done_flag, rx_done_flag}, 10'h004);
		// shift mode keeps the transmitter idle, so the fifo fills up
		for (int i = 0; i < 16; i++)
			push(xorshift());
		wr_valid = 1'b0;
		check("ready", {9'h000, wr_ready}, 10'h000);
		r = xorshift();
		cfg = aspm_cfg_type'({7'h50 | {4'h0, r[0], 2'h0}});
		drain();
		for (int i = 0; i < 6; i++)
		begin
			r = xorshift();
			cfg = aspm_cfg_type'(table_cfg[i]);
			cfg.tx_ninth_bit = r[0];
			push(xorshift());
			push(xorshift());
			wr_valid = 1'b0;
			drain();
			r = xorshift();
			rx(r, r[7], r[6], 1'b0, 0);
			rx(~r, 1'b1, 1'b1, 1'b0, 0);
			rx_clear();
			rx(r, 1'b0, 1'b0, 1'b1, 0);
			rx(~r, 1'b1, ten, 1'b1, blen(cfg, cfg.rx_timer_select) / 4);
			rx_clear();
		end
		stop_test();
	end
endmodule : testbench
